// file: rtl/vmc_pkg.sv
package vmc_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [11:0] MASTER_BUS_CONTROL_OFS = 12'h400; // Control word

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int MAX_RETRY_LSB = 28; // max_retry_limit [31:28]
  localparam int PW_COUNT_LSB = 24; // posted_write_release_count [27:24]
  localparam int REQ_LEVEL_LSB = 22; // bus_request_level [23:22]
  localparam int FAIR_BIT = 21; // request_fairness_select
  localparam int RELEASE_BIT = 20; // release_policy_select
  localparam int HOLD_BIT = 19; // hold_bus_request
  localparam int HOLD_ACK_BIT = 18; // hold_bus_acknowledge, read only
  localparam int BURST_LSB = 12; // Aligned burst size [13:12]
  localparam int BUS_NO_LSB = 0; // Local bus number [7:0]

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [3:0] MAX_RETRY_RST = 4'h8; // 1000
  localparam logic [3:0] PW_COUNT_RST = 4'h0; // 0000 = 128 bytes
  localparam logic [1:0] REQ_LEVEL_RST = 2'h3; // Level 3
  localparam logic FAIR_RST = 1'b0; // Demand
  localparam logic RELEASE_RST = 1'b0; // Release when done
  localparam logic HOLD_RST = 1'b0;
  localparam logic [1:0] BURST_RST = 2'h0;
  localparam logic [7:0] BUS_NO_RST = 8'h00;

  // ************************************************************
  // Codes and counts
  // ************************************************************
  localparam logic [3:0] PW_EVERY_TXN = 4'hF; // Release at each end
  localparam logic [3:0] PW_LAST_SIZE = 4'h5; // 4096 bytes
  localparam logic [12:0] PW_BASE_BYTES = 13'h0080; // 128 bytes
  localparam logic [3:0] RETRY_FOREVER = 4'h0;
  localparam int RETRY_UNIT_LOG2 = 6; // Multiples of 64
  localparam int CFG_BUS_LSB = 16; // Bus number in address [23:16]

  // Ownership states
  typedef enum logic [1:0] {
    VMC_IDLE,
    VMC_REQ,
    VMC_XFER,
    VMC_HOLD
  } vmc_own_e;

endpackage

// file: rtl/vmc_retry_ctr.sv
`timescale 1ns/1ps
`default_nettype none

// Counts PCI master retries of one transaction and flags the limit
module vmc_retry_ctr
  import vmc_pkg::*;
#(
  parameter int CNT_W = 10
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic txn_start,
  input wire logic retry_seen,
  input wire logic [3:0] max_retry,
  output logic retry_err
);

  // ************************************************************
  // Counter state
  // ************************************************************
  logic [CNT_W-1:0] count; // Retries so far in this transaction
  logic [CNT_W-1:0] next_count;
  logic next_retry_err;
  logic [CNT_W-1:0] limit; // Limit in retries, zero means endless

  assign limit = CNT_W'({max_retry, RETRY_UNIT_LOG2'(0)});

  // Restart per transaction, pulse on reaching the limit
  always_comb
  begin
    next_count = count;
    next_retry_err = 1'b0;
    if (txn_start)
    begin
      // Fresh budget for every transaction
      next_count = '0;
    end
    else if (retry_seen)
    begin
      // Forever mode never flags
      if (max_retry != RETRY_FOREVER && count + 1'b1 >= limit)
      begin
        next_retry_err = 1'b1;
        next_count = '0;
      end
      else
      begin
        next_count = count + 1'b1;
      end
    end
  end

  // Registers only
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      count <= '0;
      retry_err <= 1'b0;
    end
    else
    begin
      count <= next_count;
      retry_err <= next_retry_err;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  AST_RETRY_LIMIT:
    assert property (@(posedge clk) disable iff (sys_rst)
      retry_err |-> $past(max_retry) != RETRY_FOREVER
        && $past(count) == $past(limit) - 1'b1)
    else $error("retry error without reaching limit");

endmodule

`default_nettype wire

// file: rtl/vmc_master_ctl.sv
`timescale 1ns/1ps
`default_nettype none

module vmc_master_ctl
  import vmc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [11:0] reg_addr,
  input wire logic [3:0] reg_byte_en,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  // VMEbus arbitration pins
  input wire logic vme_grant_in,
  input wire logic vme_other_req,
  output logic vme_bus_req,
  output logic [1:0] vme_req_level,
  output logic vme_bbsy,
  // Posted-write master channel
  input wire logic mstr_req,
  input wire logic mstr_beat,
  input wire logic [3:0] mstr_beat_bytes,
  input wire logic mstr_txn_end,
  output logic mstr_bus_owned,
  // PCI master retry
  input wire logic pci_txn_start,
  input wire logic pci_retry,
  output logic pci_retry_err,
  // Configuration mapping
  input wire logic cfg_map_valid,
  input wire logic [31:0] cfg_vme_addr,
  output logic cfg_type_valid,
  output logic cfg_type1,
  // Aligned burst size to the slave channel
  output logic [1:0] burst_size
);

  // ************************************************************
  // Control register
  // ************************************************************
  logic [3:0] max_retry_limit;
  logic [3:0] posted_write_release_count;
  logic [1:0] bus_request_level;
  logic request_fairness_select;
  logic release_policy_select;
  logic hold_bus_request;
  logic [1:0] burst_sel;
  logic [7:0] bus_no;
  logic [31:0] ctl_word; // Assembled read image
  logic ctl_hit;
  logic [31:0] next_ctl;

  assign ctl_hit = (reg_addr == MASTER_BUS_CONTROL_OFS);

  // Byte-lane merge of a write into the stored fields
  always_comb
  begin
    next_ctl = ctl_word;
    if (reg_wr && ctl_hit)
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (reg_byte_en[b])
        begin
          next_ctl[b*8 +: 8] = reg_wdata[b*8 +: 8];
        end
      end
    end
  end

  // Register fields; the ack and reserved bits are not stored
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      max_retry_limit <= MAX_RETRY_RST;
      posted_write_release_count <= PW_COUNT_RST;
      bus_request_level <= REQ_LEVEL_RST;
      request_fairness_select <= FAIR_RST;
      release_policy_select <= RELEASE_RST;
      hold_bus_request <= HOLD_RST;
      burst_sel <= BURST_RST;
      bus_no <= BUS_NO_RST;
    end
    else
    begin
      max_retry_limit <= next_ctl[MAX_RETRY_LSB +: 4];
      posted_write_release_count <= next_ctl[PW_COUNT_LSB +: 4];
      bus_request_level <= next_ctl[REQ_LEVEL_LSB +: 2];
      request_fairness_select <= next_ctl[FAIR_BIT];
      release_policy_select <= next_ctl[RELEASE_BIT];
      hold_bus_request <= next_ctl[HOLD_BIT];
      burst_sel <= next_ctl[BURST_LSB +: 2];
      bus_no <= next_ctl[BUS_NO_LSB +: 8];
    end
  end

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [1:0] pin_meta; // First stage, read only by second
  logic [1:0] pin_sync;
  logic grant_s;
  logic other_req_s;

  // One two-flop chain per arbitration pin
  generate
    for (genvar i = 0; i < 2; i++)
    begin : g_sync
      always_ff @(posedge clk or posedge sys_rst)
      begin
        if (sys_rst)
        begin
          pin_meta[i] <= 1'b0;
          pin_sync[i] <= 1'b0;
        end
        else
        begin
          pin_meta[i] <= (i == 0) ? vme_grant_in : vme_other_req;
          pin_sync[i] <= pin_meta[i];
        end
      end
    end
  endgenerate

  assign grant_s = pin_sync[0];
  assign other_req_s = pin_sync[1];

  // ************************************************************
  // Ownership machine
  // ************************************************************
  vmc_own_e state;
  vmc_own_e next_state;
  logic [12:0] pw_bytes; // Posted-write bytes this tenure
  logic [12:0] next_pw_bytes;
  logic [12:0] pw_limit; // Byte limit from the count code
  logic [12:0] pw_sum;
  logic pw_sized; // Code is one of the six sizes
  logic parked; // ROR: done but still holding the bus
  logic next_parked;

  assign pw_sized = (posted_write_release_count <= PW_LAST_SIZE);
  // Reserved codes yield a zero limit and are never used as a size
  assign pw_limit = pw_sized ?
    (PW_BASE_BYTES << posted_write_release_count[2:0]) : '0;
  assign pw_sum = pw_bytes + 13'(mstr_beat_bytes);

  // Next ownership state
  always_comb
  begin
    next_state = state;
    next_pw_bytes = pw_bytes;
    next_parked = parked;
    case (state)
      VMC_IDLE:
      begin
        next_pw_bytes = '0;
        next_parked = 1'b0;
        // Fair mode stands back while others are requesting
        if ((hold_bus_request || mstr_req) &&
            !(request_fairness_select && other_req_s))
        begin
          next_state = VMC_REQ;
        end
      end
      VMC_REQ:
      begin
        if (grant_s)
        begin
          // Hold wins over a posted-write tenure
          next_state = hold_bus_request ? VMC_HOLD : VMC_XFER;
        end
        else if (!hold_bus_request && !mstr_req)
        begin
          next_state = VMC_IDLE;
        end
      end
      VMC_XFER:
      begin
        if (mstr_beat)
        begin
          next_pw_bytes = pw_sum;
          next_parked = 1'b0;
        end
        if (hold_bus_request)
        begin
          // Ownership now comes from the hold bit: no early release
          next_state = VMC_HOLD;
        end
        else if (mstr_beat && pw_sized && pw_sum >= pw_limit)
        begin
          next_state = VMC_IDLE;
        end
        else if (mstr_txn_end &&
                 posted_write_release_count == PW_EVERY_TXN)
        begin
          next_state = VMC_IDLE;
        end
        else if (mstr_txn_end && !release_policy_select)
        begin
          next_state = VMC_IDLE;
        end
        else if (mstr_txn_end)
        begin
          next_parked = 1'b1;
        end
        else if (parked && !mstr_req && other_req_s)
        begin
          // Release on request: give way once another master asks
          next_state = VMC_IDLE;
        end
      end
      VMC_HOLD:
      begin
        // Only a software clear ends a held tenure
        if (!hold_bus_request)
        begin
          next_state = VMC_IDLE;
        end
      end
      default:
      begin
        next_state = VMC_IDLE;
      end
    endcase
  end

  // Ownership registers
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state <= VMC_IDLE;
      pw_bytes <= '0;
      parked <= 1'b0;
    end
    else
    begin
      state <= next_state;
      pw_bytes <= next_pw_bytes;
      parked <= next_parked;
    end
  end

  // Request and busy pins and owned status follow the state; request level and burst size follow the register
  assign vme_bus_req = (state == VMC_REQ);
  assign vme_req_level = bus_request_level;
  assign vme_bbsy = (state == VMC_XFER) || (state == VMC_HOLD);
  // Posted writes may still drain while held; target path untouched
  assign mstr_bus_owned = vme_bbsy;
  assign burst_size = burst_sel;

  // Read image; ack reflects a held tenure only
  always_comb
  begin
    ctl_word = '0;
    ctl_word[MAX_RETRY_LSB +: 4] = max_retry_limit;
    ctl_word[PW_COUNT_LSB +: 4] = posted_write_release_count;
    ctl_word[REQ_LEVEL_LSB +: 2] = bus_request_level;
    ctl_word[FAIR_BIT] = request_fairness_select;
    ctl_word[RELEASE_BIT] = release_policy_select;
    ctl_word[HOLD_BIT] = hold_bus_request;
    ctl_word[HOLD_ACK_BIT] = (state == VMC_HOLD);
    ctl_word[BURST_LSB +: 2] = burst_sel;
    ctl_word[BUS_NO_LSB +: 8] = bus_no;
  end

  // Registered read data; unmapped reads return zero
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      reg_rdata <= '0;
    end
    else if (reg_rd)
    begin
      reg_rdata <= ctl_hit ? ctl_word : '0;
    end
  end

  // ************************************************************
  // Configuration cycle type
  // ************************************************************
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cfg_type_valid <= 1'b0;
      cfg_type1 <= 1'b0;
    end
    else
    begin
      cfg_type_valid <= cfg_map_valid;
      if (cfg_map_valid)
      begin
        cfg_type1 <= (cfg_vme_addr[CFG_BUS_LSB +: 8] != bus_no);
      end
    end
  end

  // ************************************************************
  // PCI retry limit
  // ************************************************************
  vmc_retry_ctr u_retry (
    .clk(clk),
    .sys_rst(sys_rst),
    .txn_start(pci_txn_start),
    .retry_seen(pci_retry),
    .max_retry(max_retry_limit),
    .retry_err(pci_retry_err)
  );

  // ************************************************************
  // Checks
  // ************************************************************
  sequence s_hold_drop;
    state == VMC_HOLD && !hold_bus_request;
  endsequence

  sequence s_count_hit;
    state == VMC_XFER && !hold_bus_request && mstr_beat && pw_sized
      && pw_sum >= pw_limit;
  endsequence

  AST_HOLD_BBSY:
    assert property (@(posedge clk) disable iff (sys_rst)
      ctl_word[HOLD_ACK_BIT] |-> vme_bbsy)
    else $error("ack without busy");
  AST_HOLD_RELEASE:
    assert property (@(posedge clk) disable iff (sys_rst)
      s_hold_drop |=> !vme_bbsy && !ctl_word[HOLD_ACK_BIT])
    else $error("busy kept after hold cleared");
  AST_NO_EARLY:
    assert property (@(posedge clk) disable iff (sys_rst)
      state == VMC_HOLD && hold_bus_request |=> vme_bbsy)
    else $error("early release while held");
  AST_PW_EARLY:
    assert property (@(posedge clk) disable iff (sys_rst)
      s_count_hit |=> !vme_bbsy)
    else $error("no release at posted-write count");
  AST_EVERY_END:
    assert property (@(posedge clk) disable iff (sys_rst)
      state == VMC_XFER && !hold_bus_request && mstr_txn_end
        && posted_write_release_count == PW_EVERY_TXN |=> !vme_bbsy)
    else $error("no release at transaction end");
  AST_CFG_TYPE:
    assert property (@(posedge clk) disable iff (sys_rst)
      cfg_map_valid |=> cfg_type_valid && cfg_type1 ==
        ($past(cfg_vme_addr[CFG_BUS_LSB +: 8]) != $past(bus_no)))
    else $error("wrong configuration cycle type");
  AST_ACK_OWNED:
    assert property (@(posedge clk) disable iff (sys_rst)
      !vme_bbsy |-> !ctl_word[HOLD_ACK_BIT])
    else $error("ack while bus not owned");
  AST_FAIR:
    assert property (@(posedge clk) disable iff (sys_rst)
      state == VMC_IDLE && request_fairness_select && other_req_s
        |=> !vme_bus_req)
    else $error("fair mode requested over others");
  AST_LIMIT_SIZE:
    assert property (@(posedge clk) disable iff (sys_rst)
      posted_write_release_count == 4'h3 |-> pw_limit == 13'h0400)
    else $error("bad posted-write size decode");

endmodule

`default_nettype wire

// file: dv/vmc_arb_model.sv
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// Arbiter and rival master stand-in
// ************************************************************
module vmc_arb_model
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic bus_req, // Request from the block
  input wire logic rival_on, // Bench wants a rival requester
  input wire logic [3:0] gnt_delay, // Cycles before grant
  output logic grant,
  output logic rival_req
);
  logic [3:0] wait_cnt; // Grant latency counter

  // Grant after a set wait; withdraw at once when request drops,
  // so a block that leans on a stale grant is caught
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wait_cnt <= 4'h0;
      grant <= 1'b0;
    end
    else if (!bus_req)
    begin
      wait_cnt <= 4'h0;
      grant <= 1'b0;
    end
    else if (wait_cnt >= gnt_delay)
      grant <= 1'b1;
    else
      wait_cnt <= wait_cnt + 4'h1;
  end

  // Rival request is a plain level from the bench
  assign rival_req = rival_on;
endmodule
`default_nettype wire

// file: dv/vme_master_bus_ownership_ctl_test.sv
`timescale 1ns/1ps
`default_nettype none

module vme_master_bus_ownership_ctl_test;
  import vmc_pkg::*;
  // ************************************************************
  // Stimulus and observed signals
  // ************************************************************
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rd_val;
  logic grant, rival, bus_req, bbsy, owned;
  logic [1:0] req_level, burst;
  logic m_req = 1'b0, m_beat = 1'b0, m_end = 1'b0;
  logic p_start = 1'b0, p_retry = 1'b0, p_err;
  logic c_valid = 1'b0, c_tvalid, c_type1;
  logic [31:0] c_addr = 32'h0;
  logic [3:0] g_dly = 4'h2; // Slow-ish arbiter
  logic rival_on = 1'b0;
  int errors = 0, n_tests = 0, n_err = 0;

  always #10 clk = ~clk; // 50 MHz

  // Count retry error pulses as they stand
  always @(posedge clk)
    if (p_err === 1'b1)
      n_err++;

  vmc_arb_model ARB (.clk(clk), .sys_rst(sys_rst), .bus_req(bus_req),
    .rival_on(rival_on), .gnt_delay(g_dly), .grant(grant),
    .rival_req(rival));

  vmc_master_ctl DUT (.clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_byte_en(4'hF),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .vme_grant_in(grant),
    .vme_other_req(rival), .vme_bus_req(bus_req),
    .vme_req_level(req_level), .vme_bbsy(bbsy), .mstr_req(m_req),
    .mstr_beat(m_beat), .mstr_beat_bytes(4'h4), .mstr_txn_end(m_end),
    .mstr_bus_owned(owned), .pci_txn_start(p_start),
    .pci_retry(p_retry), .pci_retry_err(p_err),
    .cfg_map_valid(c_valid), .cfg_vme_addr(c_addr),
    .cfg_type_valid(c_tvalid), .cfg_type1(c_type1), .burst_size(burst));

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // One compare for every kind of result
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [31:0] d);
    cyc(1);
    reg_wr = 1'b1;
    reg_addr = MASTER_BUS_CONTROL_OFS;
    reg_wdata = d;
    cyc(1);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [11:0] a);
    cyc(1);
    reg_rd = 1'b1;
    reg_addr = a;
    cyc(1);
    reg_rd = 1'b0;
    rd_val = reg_rdata;
  endtask

  // Bounded wait for bus busy; running out ends the run
  task automatic wait_bbsy(input logic v);
    int i;
    for (i = 0; i < 60 && bbsy !== v; i++)
      cyc(1);
    if (bbsy !== v)
    begin
      chk({31'h0, bbsy}, {31'h0, v});
      test_done();
    end
  endtask

  // Back-to-back four-byte beats
  task automatic beats(input int n);
    m_beat = 1'b1;
    cyc(n);
    m_beat = 1'b0;
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_regs();
    rd(MASTER_BUS_CONTROL_OFS);
    chk(rd_val, 32'h80C00000);
    chk({30'h0, req_level}, 32'h3);
    wr(32'hFFF030FF);
    rd(MASTER_BUS_CONTROL_OFS);
    chk(rd_val, 32'hFFF030FF);
    chk({30'h0, burst}, 32'h3);
    chk({30'h0, req_level}, 32'h3);
    wr(32'h00000000);
    rd(MASTER_BUS_CONTROL_OFS);
    chk(rd_val, 32'h00000000);
    chk({30'h0, req_level}, 32'h0);
    rd(12'h404); // Unmapped place
    chk(rd_val, 32'h00000000);
    $display("regs done");
  endtask

  // Early release at the byte count, codes 0 and 1
  task automatic t_post();
    int c;
    for (c = 0; c < 2; c++)
    begin
      wr(32'h80C00000 | (c << PW_COUNT_LSB));
      m_req = 1'b1;
      wait_bbsy(1'b1);
      beats(((128 << c) / 4) - 1);
      chk({31'h0, bbsy}, 32'h1);
      m_req = 1'b0;
      // Let an edge pass so the beat strobe is not driven twice
      cyc(1);
      beats(1);
      cyc(1);
      chk({31'h0, bbsy}, 32'h0);
      chk({31'h0, owned}, 32'h0);
    end
    wr(32'h8FD00000); // Every end, even in release on request
    m_req = 1'b1;
    wait_bbsy(1'b1);
    beats(3);
    m_req = 1'b0;
    m_end = 1'b1;
    cyc(1);
    m_end = 1'b0;
    cyc(1);
    chk({31'h0, bbsy}, 32'h0);
    $display("posted done");
  endtask

  // Fair mode stands back for a rival; release on request parks
  task automatic t_arb();
    wr(32'h80E00000); // Fair, release when done
    rival_on = 1'b1;
    cyc(3);
    m_req = 1'b1;
    cyc(4);
    chk({31'h0, bus_req}, 32'h0);
    rival_on = 1'b0;
    wait_bbsy(1'b1);
    m_req = 1'b0;
    m_end = 1'b1;
    cyc(1);
    m_end = 1'b0;
    cyc(1);
    chk({31'h0, bbsy}, 32'h0);
    wr(32'h80D00000); // Release on request
    m_req = 1'b1;
    wait_bbsy(1'b1);
    m_req = 1'b0;
    m_end = 1'b1;
    cyc(1);
    m_end = 1'b0;
    cyc(3);
    chk({31'h0, bbsy}, 32'h1);
    rival_on = 1'b1;
    cyc(4);
    chk({31'h0, bbsy}, 32'h0);
    rival_on = 1'b0;
    wr(32'h86C00000); // Reserved count code, no early release
    m_req = 1'b1;
    wait_bbsy(1'b1);
    beats(40);
    chk({31'h0, bbsy}, 32'h1);
    m_req = 1'b0;
    m_end = 1'b1;
    cyc(1);
    m_end = 1'b0;
    cyc(1);
    chk({31'h0, bbsy}, 32'h0);
    $display("arbitration done");
  endtask

  // Hold ownership beats the transaction-end release path (code F)
  task automatic t_hold();
    rd(MASTER_BUS_CONTROL_OFS);
    chk(rd_val >> HOLD_ACK_BIT & 32'h1, 32'h0);
    g_dly = 4'h6;
    wr(32'h8FC80000);
    wait_bbsy(1'b1);
    rd(MASTER_BUS_CONTROL_OFS);
    chk(rd_val, 32'h8FCC0000);
    m_req = 1'b1;
    beats(40);
    chk({31'h0, owned}, 32'h1);
    m_req = 1'b0;
    m_end = 1'b1;
    cyc(1);
    m_end = 1'b0;
    cyc(3);
    chk({31'h0, bbsy}, 32'h1);
    chk({31'h0, bus_req & ~bbsy}, 32'h0);
    wr(32'h8FC00000);
    cyc(1);
    chk({31'h0, bbsy}, 32'h0);
    rd(MASTER_BUS_CONTROL_OFS);
    chk(rd_val, 32'h8FC00000);
    g_dly = 4'h2;
    $display("hold done");
  endtask

  // Retry limit 64, count restarted by a new transaction
  task automatic t_retry();
    wr(32'h10C00000);
    p_start = 1'b1;
    cyc(1);
    p_start = 1'b0;
    p_retry = 1'b1;
    cyc(40);
    p_retry = 1'b0;
    p_start = 1'b1;
    cyc(1);
    p_start = 1'b0;
    p_retry = 1'b1;
    cyc(63);
    p_retry = 1'b0;
    cyc(3);
    chk(n_err, 32'h0);
    p_retry = 1'b1;
    cyc(1);
    p_retry = 1'b0;
    cyc(3);
    chk(n_err, 32'h1);
    wr(32'h00C00000); // Retry forever
    p_retry = 1'b1;
    cyc(70);
    p_retry = 1'b0;
    cyc(3);
    chk(n_err, 32'h1);
    $display("retry done");
  endtask

  // Type 0 on bus number match, Type 1 otherwise
  task automatic t_cfg();
    int i;
    wr(32'h80C00012);
    for (i = 0; i < 2; i++)
    begin
      c_addr = 32'h00120000 + (i << CFG_BUS_LSB);
      c_valid = 1'b1;
      cyc(1);
      c_valid = 1'b0;
      chk({30'h0, c_tvalid, c_type1}, {30'h1, i[0]});
      cyc(1);
      chk({31'h0, c_tvalid}, 32'h0);
    end
    $display("cfg done");
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    cyc(2);
    sys_rst = 1'b0;
    t_regs();
    t_post();
    t_arb();
    t_hold();
    t_retry();
    t_cfg();
    test_done();
  end
endmodule
`default_nettype wire
